// ==== design/rec_mix_pkg.sv ====
package rec_mix_pkg;
    // channel and word geometry
    localparam int NCH       = 4;
    localparam int SAMPLE_W  = 24;
    localparam int COEF_W    = 32;
    localparam int MIX_FRAC  = 31;
    localparam int MIX_ACC_W = SAMPLE_W + COEF_W + 2;

    // mixer coefficient landmarks, 1.31 two's complement
    localparam logic [COEF_W-1:0] COEF_UNITY     = 32'h7FFFFFFF;
    localparam logic [COEF_W-1:0] COEF_MUTE      = 32'h00000000;
    localparam logic [COEF_W-1:0] COEF_UNITY_INV = 32'h80000001;
    localparam logic [COEF_W-1:0] COEF_RESET_OFF = 32'h00000000;

    // biquad coefficient placement in paged space
    localparam logic [6:0] BQ_FIRST_REG = 7'h08;
    localparam logic [6:0] BQ_REGS      = 7'h14;
    localparam logic [3:0] BQ_PER_PAGE  = 4'h6;
    localparam logic [7:0] BQ_PAGE_LO   = 8'h02;
    localparam logic [7:0] BQ_PAGE_HI   = 8'h03;

    typedef enum logic [1:0] {
        SUM_NONE = 2'b00,
        SUM_PAIR = 2'b01,
        SUM_RSV2 = 2'b10,
        SUM_RSV3 = 2'b11
    } pair_sum_t;

    typedef enum logic [1:0] {
        DEC_LINEAR = 2'b00,
        DEC_LOWLAT = 2'b01,
        DEC_ULTRA  = 2'b10,
        DEC_RSV    = 2'b11
    } dec_type_t;

    typedef enum logic [1:0] {
        BQ_OFF   = 2'b00,
        BQ_ONE   = 2'b01,
        BQ_TWO   = 2'b10,
        BQ_THREE = 2'b11
    } bq_alloc_t;

    typedef logic signed [SAMPLE_W-1:0] sample_t;
    localparam sample_t SAMPLE_MAX = 24'h7FFFFF;
    localparam sample_t SAMPLE_MIN = 24'h800000;

    typedef struct packed {
        logic                   valid;
        sample_t [NCH-1:0]      ch;
    } frame_t;

    typedef struct packed {
        logic                   valid;
        logic [7:0]             page;
        logic [6:0]             addr;
    } bq_wr_t;

    typedef struct packed {
        logic                   hit;
        logic [3:0]             index;
        logic [4:0]             byte_sel;
        logic [2:0]             channel;
        logic                   active;
    } bq_map_t;

    typedef struct packed {
        logic                   valid;
        logic [1:0]             dst;
        logic [1:0]             src;
        logic [COEF_W-1:0]      data;
    } mix_wr_t;
endpackage

// ==== design/dec_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module dec_channel #(
    parameter int ACC_W = 16                           // pdm tally width
) (
    input  wire logic                     clk,         // 50 MHz clock
    input  wire logic                     reset_n,     // async reset
    input  wire logic                     enable,      // channel powered
    input  wire logic                     pdm_tick,    // pdm bit valid
    input  wire logic                     pdm_bit,     // pdm data bit
    input  wire logic                     frame_sync,  // output rate pulse
    input  wire rec_mix_pkg::dec_type_t   dec_type,    // filter family
    output var  rec_mix_pkg::sample_t     sample_r,    // decimated sample
    output var  logic                     valid_r      // one-cycle strobe
);
    localparam int W = rec_mix_pkg::SAMPLE_W + 2;

    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] step;
    logic signed [ACC_W-1:0] tally;
    rec_mix_pkg::sample_t    h1_r;
    rec_mix_pkg::sample_t    h2_r;
    logic signed [W-1:0]     x_w;
    logic signed [W-1:0]     h1_w;
    logic signed [W-1:0]     h2_w;
    logic signed [W-1:0]     y_w;

    // a bit that lands with frame_sync still counts in the closing frame
    assign step  = pdm_bit ? ACC_W'(1) : {ACC_W{1'b1}};
    assign tally = pdm_tick ? ACC_W'(acc_r + step) : acc_r;
    assign x_w   = W'(tally);
    assign h1_w  = W'(h1_r);
    assign h2_w  = W'(h2_r);

    // post-dump kernels; symmetric one keeps phase exactly linear
    // limitation: stand-in kernels, the ripple, stop-band and delay targets are not reached
    always_comb begin
        case (dec_type)
            rec_mix_pkg::DEC_LOWLAT: y_w = (x_w + (x_w <<< 1) + h1_w) >>> 2;
            rec_mix_pkg::DEC_ULTRA:  y_w = x_w;
            default:                 y_w = (x_w + (h1_w <<< 1) + h2_w) >>> 2;
        endcase
    end

    // integrate and dump once per frame_sync
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r    <= '0;
            h1_r     <= '0;
            h2_r     <= '0;
            sample_r <= '0;
            valid_r  <= 1'b0;
        end else if (!enable) begin
            acc_r    <= '0;
            h1_r     <= '0;
            h2_r     <= '0;
            valid_r  <= 1'b0;
        end else begin
            valid_r <= frame_sync;
            if (frame_sync) begin
                acc_r    <= '0;
                h1_r     <= rec_mix_pkg::sample_t'(x_w);
                h2_r     <= h1_r;
                sample_r <= rec_mix_pkg::sample_t'(y_w);
            end else begin
                acc_r <= tally;
            end
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);

    frame_rate_a: assert property (enable && frame_sync |=> valid_r)
        else $error("no sample after frame_sync");
    one_per_frame_a: assert property (!(enable && frame_sync) |=> !valid_r)
        else $error("sample without frame_sync");
    ultra_pass_a: assert property (
        enable && frame_sync && dec_type == rec_mix_pkg::DEC_ULTRA
        |=> sample_r == rec_mix_pkg::sample_t'($past(x_w)))
        else $error("ultra-low latency path not direct");
endmodule
`default_nettype wire

// ==== design/record_channel_mix_decimate.sv ====
`timescale 1ns/1ps
`default_nettype none
module record_channel_mix_decimate #(
    parameter int ACC_W = 16                               // pdm tally width
) (
    input  wire logic                       clk,           // 50 MHz clock
    input  wire logic                       reset_n,       // async reset
    input  wire logic                       rec_power,     // recording powered
    input  wire logic                       pdm_tick,      // pdm bits valid
    input  wire logic [3:0]                 pdm_data,      // one bit per mic
    input  wire logic                       frame_sync,    // output rate pulse
    input  wire rec_mix_pkg::pair_sum_t     pair_sum_select,       // summing
    input  wire rec_mix_pkg::dec_type_t     decimator_type_select, // filter
    input  wire rec_mix_pkg::bq_alloc_t     biquad_alloc,  // biquads per output
    input  wire rec_mix_pkg::bq_wr_t        bq_wr,         // biquad reg access
    input  wire rec_mix_pkg::mix_wr_t       mix_wr,        // mixer coef write
    output var  rec_mix_pkg::frame_t        out_frame_r,   // output samples
    output var  rec_mix_pkg::bq_map_t       bq_map_r,      // biquad decode
    output var  logic                       mix_wr_refused_r, // write refused
    output var  logic                       cfg_reserved_r // reserved setting
);
    localparam int NCH  = rec_mix_pkg::NCH;
    localparam int NC   = NCH * NCH;
    localparam int AW   = rec_mix_pkg::MIX_ACC_W;
    localparam int PW   = rec_mix_pkg::SAMPLE_W + 1;
    localparam logic signed [AW-1:0] MIX_ROUND = AW'(64'h0000_0000_4000_0000);
    localparam logic signed [AW-1:0] ACC_MAX   = AW'(rec_mix_pkg::SAMPLE_MAX);
    localparam logic signed [AW-1:0] ACC_MIN   = AW'(rec_mix_pkg::SAMPLE_MIN);

    rec_mix_pkg::sample_t               dec_ch [NCH];
    logic [NCH-1:0]                     dec_valid;
    logic signed [rec_mix_pkg::COEF_W-1:0] staged_r [NC];
    logic signed [rec_mix_pkg::COEF_W-1:0] active_r [NC];
    logic                               pwr_d_r;
    logic                               power_rise;
    logic                               mix_accept;
    logic [3:0]                         mix_idx;
    logic signed [AW-1:0]               mix_acc [NCH];
    rec_mix_pkg::sample_t               mixed [NCH];
    rec_mix_pkg::sample_t               avg12;
    rec_mix_pkg::sample_t               avg34;
    rec_mix_pkg::sample_t [NCH-1:0]     out_nxt;
    logic                               bq_page_ok;
    logic                               bq_page_hi;
    logic [6:0]                         bq_off;
    logic [6:0]                         bq_q;
    logic [6:0]                         bq_rem;
    logic [3:0]                         bq_idx;
    logic [3:0]                         bq_idx_m1;
    logic [3:0]                         bq_limit;
    rec_mix_pkg::bq_map_t               bq_map_nxt;

    // clamp a wide mixer sum into sample range rather than let it wrap
    function automatic rec_mix_pkg::sample_t sat_acc(input logic signed [AW-1:0] v);
        if (v > ACC_MAX) begin
            return rec_mix_pkg::SAMPLE_MAX;
        end else if (v < ACC_MIN) begin
            return rec_mix_pkg::SAMPLE_MIN;
        end
        return rec_mix_pkg::sample_t'(v);
    endfunction

    // equal-weight pair average; extra bit keeps the sum from overflowing
    function automatic rec_mix_pkg::sample_t pair_avg(
        input rec_mix_pkg::sample_t a,
        input rec_mix_pkg::sample_t b
    );
        logic signed [PW-1:0] s;
        s = PW'(a) + PW'(b);
        return rec_mix_pkg::sample_t'(s >>> 1);
    endfunction

    // one decimator per microphone, all fed the same frame_sync
    for (genvar c = 0; c < NCH; c++) begin : g_dec
        dec_channel #(
            .ACC_W      (ACC_W)
        ) u_dec (
            .clk        (clk),
            .reset_n    (reset_n),
            .enable     (rec_power),
            .pdm_tick   (pdm_tick),
            .pdm_bit    (pdm_data[c]),
            .frame_sync (frame_sync),
            .dec_type   (decimator_type_select),
            .sample_r   (dec_ch[c]),
            .valid_r    (dec_valid[c])
        );
    end

    // biquad register decode: 20 registers per biquad from register 8
    assign bq_page_hi = (bq_wr.page == rec_mix_pkg::BQ_PAGE_HI);
    assign bq_page_ok = (bq_wr.page == rec_mix_pkg::BQ_PAGE_LO) || bq_page_hi;
    assign bq_off     = bq_wr.addr - rec_mix_pkg::BQ_FIRST_REG;
    assign bq_q       = bq_off / rec_mix_pkg::BQ_REGS;
    assign bq_rem     = bq_off % rec_mix_pkg::BQ_REGS;
    assign bq_idx     = bq_q[3:0] + 4'h1 + (bq_page_hi ? rec_mix_pkg::BQ_PER_PAGE : 4'h0);
    assign bq_idx_m1  = bq_idx - 4'h1;
    assign bq_limit   = {biquad_alloc, 2'b00};

    // allocation: biquad k lands on output ((k-1) mod 4)+1
    always_comb begin
        bq_map_nxt          = '0;
        bq_map_nxt.hit      = bq_wr.valid && bq_page_ok &&
                              (bq_wr.addr >= rec_mix_pkg::BQ_FIRST_REG);
        bq_map_nxt.index    = bq_idx;
        bq_map_nxt.byte_sel = bq_rem[4:0];
        bq_map_nxt.channel  = {1'b0, bq_idx_m1[1:0]} + 3'h1;
        bq_map_nxt.active   = (biquad_alloc != rec_mix_pkg::BQ_OFF) &&
                              (bq_idx <= bq_limit);
    end

    // coefficient writes land only while the record path is down
    assign mix_idx    = {mix_wr.dst, mix_wr.src};
    assign mix_accept = mix_wr.valid && !rec_power;
    assign power_rise = rec_power && !pwr_d_r;

    // staged set takes writes; active set copies it at power-up so a
    // running mix never sees a half-updated coefficient row
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NC; i++) begin
                staged_r[i] <= (i / NCH == i % NCH) ? rec_mix_pkg::COEF_UNITY
                                                    : rec_mix_pkg::COEF_RESET_OFF;
                active_r[i] <= (i / NCH == i % NCH) ? rec_mix_pkg::COEF_UNITY
                                                    : rec_mix_pkg::COEF_RESET_OFF;
            end
            pwr_d_r          <= 1'b0;
            mix_wr_refused_r <= 1'b0;
        end else begin
            pwr_d_r          <= rec_power;
            mix_wr_refused_r <= mix_wr.valid && rec_power;
            if (mix_accept) begin
                staged_r[mix_idx] <= mix_wr.data;
            end
            if (power_rise) begin
                for (int i = 0; i < NC; i++) begin
                    active_r[i] <= staged_r[i];
                end
            end
        end
    end

    // four mixers, each a rounded 1.31 weighted sum of all inputs
    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            mix_acc[n] = MIX_ROUND;
            for (int k = 0; k < NCH; k++) begin
                mix_acc[n] = mix_acc[n] + AW'(signed'(dec_ch[k])) *
                             AW'(active_r[n * NCH + k]);
            end
            mixed[n] = sat_acc(mix_acc[n] >>> rec_mix_pkg::MIX_FRAC);
        end
    end

    assign avg12 = pair_avg(dec_ch[0], dec_ch[1]);
    assign avg34 = pair_avg(dec_ch[2], dec_ch[3]);

    // summing select chooses mixer, pair average or plain bypass
    always_comb begin
        case (pair_sum_select)
            rec_mix_pkg::SUM_NONE: begin
                for (int n = 0; n < NCH; n++) begin
                    out_nxt[n] = mixed[n];
                end
            end
            rec_mix_pkg::SUM_PAIR: begin
                out_nxt[0] = avg12;
                out_nxt[1] = avg12;
                out_nxt[2] = avg34;
                out_nxt[3] = avg34;
            end
            default: begin
                // reserved codes: mixer stays bypassed, samples go straight out
                for (int n = 0; n < NCH; n++) begin
                    out_nxt[n] = dec_ch[n];
                end
            end
        endcase
    end

    // output stage and status flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_frame_r    <= '0;
            bq_map_r       <= '0;
            cfg_reserved_r <= 1'b0;
        end else begin
            out_frame_r.valid <= dec_valid[0];
            if (dec_valid[0]) begin
                out_frame_r.ch <= out_nxt;
            end
            bq_map_r       <= bq_map_nxt;
            cfg_reserved_r <= (pair_sum_select == rec_mix_pkg::SUM_RSV2) ||
                              (pair_sum_select == rec_mix_pkg::SUM_RSV3) ||
                              (decimator_type_select == rec_mix_pkg::DEC_RSV);
        end
    end

    default clocking mc @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence frame_in(rec_mix_pkg::pair_sum_t m);
        dec_valid[0] && pair_sum_select == m;
    endsequence

    sequence row0_is(logic [31:0] c0);
        active_r[0] == c0 && active_r[1] == 32'h0 && active_r[2] == 32'h0 &&
        active_r[3] == 32'h0;
    endsequence

    bq_first_a: assert property (
        bq_wr.valid && bq_wr.page == 8'h02 && bq_wr.addr == 7'h08
        |=> bq_map_r.hit && bq_map_r.index == 4'h1 && bq_map_r.byte_sel == 5'h00)
        else $error("biquad 1 not at page 2 register 8");
    bq_last_a: assert property (
        bq_wr.valid && bq_wr.page == 8'h03 && bq_wr.addr == 7'h7F
        |=> bq_map_r.hit && bq_map_r.index == 4'hC && bq_map_r.byte_sel == 5'h13)
        else $error("biquad 12 end misplaced");
    bq_alloc_a: assert property (
        bq_wr.valid && bq_wr.page == 8'h02 && bq_wr.addr == 7'h58 &&
        biquad_alloc == rec_mix_pkg::BQ_ONE
        |=> bq_map_r.hit && !bq_map_r.active && bq_map_r.channel == 3'h1)
        else $error("biquad 5 allocation wrong");
    pair_low_a: assert property (
        frame_in(rec_mix_pkg::SUM_PAIR)
        |=> out_frame_r.valid && out_frame_r.ch[0] == out_frame_r.ch[1] &&
            out_frame_r.ch[0] == $past(avg12))
        else $error("pair sum of channels 1 and 2 wrong");
    pair_high_a: assert property (
        frame_in(rec_mix_pkg::SUM_PAIR)
        |=> out_frame_r.ch[2] == out_frame_r.ch[3] && out_frame_r.ch[3] == $past(avg34))
        else $error("pair sum of channels 3 and 4 wrong");
    bypass_rsv_a: assert property (
        frame_in(rec_mix_pkg::SUM_RSV2) |=> out_frame_r.ch[1] == $past(dec_ch[1]))
        else $error("mixer not bypassed");
    unity_pass_a: assert property (
        frame_in(rec_mix_pkg::SUM_NONE) and row0_is(rec_mix_pkg::COEF_UNITY)
        |=> out_frame_r.ch[0] == $past(dec_ch[0]))
        else $error("unity coefficient not transparent");
    mute_row_a: assert property (
        frame_in(rec_mix_pkg::SUM_NONE) and row0_is(rec_mix_pkg::COEF_MUTE)
        |=> out_frame_r.ch[0] == 24'h000000)
        else $error("mute coefficient leaks");
    invert_a: assert property (
        frame_in(rec_mix_pkg::SUM_NONE) and row0_is(rec_mix_pkg::COEF_UNITY_INV) and
        dec_ch[0] != rec_mix_pkg::SAMPLE_MIN
        |=> out_frame_r.ch[0] == -$past(dec_ch[0]))
        else $error("negative coefficient does not invert");
    sat_high_a: assert property (
        frame_in(rec_mix_pkg::SUM_NONE) and (mix_acc[0] >>> 31) > ACC_MAX
        |=> out_frame_r.ch[0] == rec_mix_pkg::SAMPLE_MAX)
        else $error("mixer sum wrapped");
    wr_refused_a: assert property (
        mix_wr.valid && rec_power
        |=> mix_wr_refused_r && staged_r[$past(mix_idx)] == $past(staged_r[mix_idx]))
        else $error("write while powered not refused");
    activate_a: assert property (
        power_rise |=> active_r[5] == $past(staged_r[5]))
        else $error("staged coefficients not taken at power-up");

    // output stream: one strobe two edges after a powered frame_sync
    sequence frame_close;
        rec_power && frame_sync;
    endsequence

    sequence strobe_out;
        ##2 out_frame_r.valid;
    endsequence

    out_lag_a: assert property (frame_close |-> strobe_out)
        else $error("output strobe not two cycles after frame_sync");
    out_quiet_a: assert property (!dec_valid[0] |=> !out_frame_r.valid)
        else $error("output strobe without decimated sample");
    out_hold_a: assert property (!dec_valid[0] |=> $stable(out_frame_r.ch))
        else $error("output samples moved between strobes");

    // identity detector for the pass-through checks; an identity mix would
    // hide a broken bypass, so the pair-mode check excludes it
    logic mix_ident;
    always_comb begin
        mix_ident = 1'b1;
        for (int i = 0; i < NC; i++) begin
            if (active_r[i] != ((i / NCH == i % NCH) ? rec_mix_pkg::COEF_UNITY
                                                      : rec_mix_pkg::COEF_MUTE)) begin
                mix_ident = 1'b0;
            end
        end
    end

    pass_ident_a: assert property (
        frame_in(rec_mix_pkg::SUM_NONE) and mix_ident
        |=> out_frame_r.ch[2] == $past(dec_ch[2]) && out_frame_r.ch[3] == $past(dec_ch[3]))
        else $error("identity mix does not pass samples through");
    pair_skip_a: assert property (
        frame_in(rec_mix_pkg::SUM_PAIR) and !mix_ident
        |=> out_frame_r.ch[1] == $past(avg12))
        else $error("mixer not bypassed in pair mode");

    // biquad decode refusals and corner placements
    bq_page_miss_a: assert property (
        bq_wr.valid && bq_wr.page != 8'h02 && bq_wr.page != 8'h03 |=> !bq_map_r.hit)
        else $error("biquad hit outside pages two and three");
    bq_low_reg_a: assert property (
        bq_wr.valid && bq_wr.addr < 7'h08 |=> !bq_map_r.hit)
        else $error("biquad hit below register 8");
    bq_seventh_a: assert property (
        bq_wr.valid && bq_wr.page == 8'h03 && bq_wr.addr == 7'h08
        |=> bq_map_r.index == 4'h7 && bq_map_r.channel == 3'h3)
        else $error("biquad 7 not at page 3 register 8");
    bq_off_a: assert property (
        bq_wr.valid && biquad_alloc == rec_mix_pkg::BQ_OFF |=> !bq_map_r.active)
        else $error("biquad active with allocation off");
    bq_three_a: assert property (
        bq_wr.valid && bq_wr.page == 8'h03 && bq_wr.addr == 7'h7F &&
        biquad_alloc == rec_mix_pkg::BQ_THREE
        |=> bq_map_r.active && bq_map_r.channel == 3'h4)
        else $error("biquad 12 not on output 4");

    // refusal pulse only for powered writes; live set moves only at power-up,
    // so a running mix never picks up a half-written row
    refuse_quiet_a: assert property (
        !(mix_wr.valid && rec_power) |=> !mix_wr_refused_r)
        else $error("refusal flagged without a powered write");
    active_hold_a: assert property (
        !power_rise |=> $stable(active_r[0]) && $stable(active_r[15]))
        else $error("live coefficients changed outside power-up");

    // legal settings never raise the reserved flag
    legal_flag_a: assert property (
        pair_sum_select inside {rec_mix_pkg::SUM_NONE, rec_mix_pkg::SUM_PAIR} &&
        decimator_type_select != rec_mix_pkg::DEC_RSV |=> !cfg_reserved_r)
        else $error("legal setting flagged reserved");
endmodule
`default_nettype wire

// ==== verif/pdm_mic_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdm_mic_model (
    input  wire logic            clk,        // system clock
    input  wire logic            reset_n,    // async reset
    input  wire logic            pdm_tick,   // bit strobe
    input  wire logic            frame_sync, // frame boundary
    input  wire logic [3:0][4:0] ones,       // ones per frame, per mic
    output logic [3:0]           pdm_data    // one bit per mic
);
    logic [4:0] pos_r;
    logic [3:0] bits;
    // tick position inside the current frame
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            pos_r <= 5'h00;
        else if (frame_sync)
            pos_r <= 5'h00;
        else if (pdm_tick)
            pos_r <= pos_r + 5'h01;
    end
    // density as leading ones; off-tick the line flips so stale bits never pass
    always_comb begin
        for (int c = 0; c < 4; c++)
            bits[c] = pos_r < ones[c];
        pdm_data = pdm_tick ? bits : ~bits;
    end
endmodule
`default_nettype wire

// ==== verif/record_channel_mix_decimate_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module record_channel_mix_decimate_tb;
    localparam int N = 16; // ticks per frame, fits ACC_W of 8
    logic clk = 0, reset_n = 0, rec_power = 0, pdm_tick = 0, frame_sync = 0, refused, reserved;
    logic [3:0] pdm_data;
    logic [3:0][4:0] ones = '0;
    rec_mix_pkg::pair_sum_t psel = rec_mix_pkg::SUM_NONE;
    rec_mix_pkg::dec_type_t dsel = rec_mix_pkg::DEC_LINEAR;
    rec_mix_pkg::bq_alloc_t alloc = rec_mix_pkg::BQ_OFF;
    rec_mix_pkg::bq_wr_t bq_wr = '0;
    rec_mix_pkg::mix_wr_t mix_wr = '0;
    rec_mix_pkg::frame_t frame, exp_q[$];
    rec_mix_pkg::bq_map_t bq_map, bq_q[$], b, bw;
    logic bq_pend = 0;
    int fail_count = 0, checks_done = 0, seed = 53829, h1[4], h2[4];
    longint coef[4][4];
    logic [31:0] ctab[5] = '{32'h7FFFFFFF, 32'h00000000, 32'h80000001, 32'h40000000, 32'hC0000000};

    record_channel_mix_decimate #(.ACC_W(8)) u_record_channel_mix_decimate (
        .clk(clk), .reset_n(reset_n), .rec_power(rec_power), .pdm_tick(pdm_tick),
        .pdm_data(pdm_data), .frame_sync(frame_sync), .pair_sum_select(psel),
        .decimator_type_select(dsel), .biquad_alloc(alloc), .bq_wr(bq_wr), .mix_wr(mix_wr),
        .out_frame_r(frame), .bq_map_r(bq_map), .mix_wr_refused_r(refused),
        .cfg_reserved_r(reserved));
    pdm_mic_model u_pdm_mic_model (.clk(clk), .reset_n(reset_n), .pdm_tick(pdm_tick),
        .frame_sync(frame_sync), .ones(ones), .pdm_data(pdm_data));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic check(string what, logic [96:0] seen, logic [96:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // result watcher: oldest note is compared whenever an answer shows
    always @(posedge clk) begin
        if (frame.valid) begin
            check("reserved flag", reserved, 1'b0);
            if (exp_q.size() == 0)
                check("frame count", 1'b1, 1'b0);
            else
                check("frame", frame, exp_q.pop_front());
        end
        if (bq_pend) begin
            bw = bq_q.pop_front();
            check("bq map", bw.hit ? bq_map : bq_map.hit, bw.hit ? bw : bw.hit);
        end
        bq_pend <= bq_wr.valid;
    end

    // one frame of pdm bits, then the expected filtered and mixed samples
    task automatic run_frame();
        logic [3:0][4:0] o;
        int x, y[4];
        longint acc;
        rec_mix_pkg::frame_t e;
        for (int c = 0; c < 4; c++)
            o[c] = 5'($unsigned($random(seed)) % (N + 1));
        ones <= o;
        repeat (N) begin
            @(posedge clk) pdm_tick <= 1;
            @(posedge clk) pdm_tick <= 0;
        end
        @(posedge clk) frame_sync <= 1;
        @(posedge clk) frame_sync <= 0;
        for (int c = 0; c < 4; c++) begin
            x = 2 * o[c] - N;
            case (dsel)
                rec_mix_pkg::DEC_LOWLAT: y[c] = (3 * x + h1[c]) >>> 2;
                rec_mix_pkg::DEC_ULTRA: y[c] = x;
                default: y[c] = (x + 2 * h1[c] + h2[c]) >>> 2;
            endcase
            h2[c] = h1[c];
            h1[c] = x;
        end
        e.valid = 1'b1;
        for (int n = 0; n < 4; n++) begin
            acc = 0;
            for (int k = 0; k < 4; k++)
                acc += y[k] * coef[n][k];
            acc = (acc + 2 ** 30) >>> 31;
            e.ch[n] = (psel == rec_mix_pkg::SUM_PAIR) ?
                      24'((y[n & 2] + y[(n & 2) + 1]) >>> 1) : acc[23:0];
        end
        exp_q.push_back(e);
    endtask

    // coefficients take hold only from a fresh power-up
    task automatic session(rec_mix_pkg::pair_sum_t s, rec_mix_pkg::dec_type_t d);
        @(posedge clk) rec_power <= 0;
        psel <= s;
        dsel <= d;
        h1 = '{0, 0, 0, 0};
        h2 = '{0, 0, 0, 0};
        @(posedge clk) rec_power <= 1;
        repeat (2) @(posedge clk);
        repeat (3) run_frame();
        for (int i = 0; i < 20 && exp_q.size() > 0; i++)
            @(posedge clk);
        if (exp_q.size() > 0) begin
            check("frame timeout", 1'b1, 1'b0);
            give_verdict();
        end
    endtask

    task automatic mix_write(int d, int s, logic [31:0] v);
        @(posedge clk) mix_wr <= '{1'b1, 2'(d), 2'(s), v};
        @(posedge clk) mix_wr.valid <= 0;
        #1 check("write refused", refused, rec_power);
        if (!rec_power)
            coef[d][s] = $signed(v);
    endtask

    initial begin
        for (int n = 0; n < 4; n++)
            for (int k = 0; k < 4; k++)
                coef[n][k] = (n == k) ? 32'h7FFFFFFF : 0;
        repeat (12) @(posedge clk);
        reset_n <= 1;
        // every filter family, identity mixer out of reset
        for (int d = 0; d < 3; d++)
            session(rec_mix_pkg::SUM_NONE, rec_mix_pkg::dec_type_t'(d));
        session(rec_mix_pkg::SUM_PAIR, rec_mix_pkg::DEC_LINEAR);
        // load a random mix while powered down; host order as for biquads
        @(posedge clk) rec_power <= 0;
        for (int n = 0; n < 4; n++)
            for (int k = 0; k < 4; k++)
                mix_write(n, k, ctab[$unsigned($random(seed)) % 5]);
        session(rec_mix_pkg::SUM_NONE, rec_mix_pkg::DEC_ULTRA);
        session(rec_mix_pkg::SUM_PAIR, rec_mix_pkg::DEC_ULTRA);
        mix_write(0, 0, 32'h00000000);
        session(rec_mix_pkg::SUM_NONE, rec_mix_pkg::DEC_LOWLAT);
        // biquad placement decode, back to back, every allocation
        for (int i = 0; i < 160; i++) begin
            b.hit = 0;
            @(posedge clk) alloc <= rec_mix_pkg::bq_alloc_t'(i / 40);
            bq_wr <= '{1'b1, 8'($unsigned($random(seed)) % 5), 7'($random(seed))};
            #1 b.hit = (bq_wr.page == 8'h02 || bq_wr.page == 8'h03) && bq_wr.addr >= 7'h08;
            b.index = 4'((bq_wr.page - 2) * 6 + (bq_wr.addr - 8) / 20 + 1);
            b.byte_sel = 5'((bq_wr.addr - 8) % 20);
            b.channel = 3'((b.index - 1) % 4 + 1);
            b.active = alloc != rec_mix_pkg::BQ_OFF && b.index <= 4 * alloc;
            bq_q.push_back(b);
        end
        @(posedge clk) bq_wr <= '0;
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
`default_nettype wire
